// ---- pkg/timebase_pkg.sv ----
package timebase_pkg;

  localparam int clk_mhz = 125;
  localparam int holdoff_us = 13500;
  localparam int holdoff_cycles = holdoff_us * clk_mhz;
  localparam int shaper_ns = 1000;
  localparam int shaper_cycles = (shaper_ns * clk_mhz + 999) / 1000;

  localparam int b_decades = 6;
  localparam int a_decades = 7;
  localparam logic [3:0] detect_60hz = 4'h6;
  localparam logic [3:0] detect_50hz = 4'h5;
  localparam logic [3:0] decade_last = 4'h9;
  localparam logic [3:0] minute_last = 4'h5;
  localparam int crystal_div = 1000;

  localparam logic [31:0] reg_control = 32'h0000_0000;
  localparam logic [31:0] reg_status = 32'h0000_0004;
  localparam logic [31:0] reg_count_b = 32'h0000_0008;

  localparam int ctl_source_lsb = 0;
  localparam int ctl_mains50 = 2;
  localparam int ctl_crystal = 3;
  localparam int ctl_selfcheck = 4;
  localparam int ctl_system_gate = 5;
  localparam int ctl_preset_idle = 6;
  localparam logic [31:0] ctl_reset_value = 32'h0000_0060;

  typedef enum logic [1:0] {
    source_external,
    source_tenth_second,
    source_tenth_minute
  } source_type;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } wb_req_type;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } wb_rsp_type;

endpackage : timebase_pkg

// ---- rtl/pulse_stretch.sv ----
`timescale 1ns/1ps
module pulse_stretch
  import timebase_pkg::*;
#(
  parameter int length = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Trigger
  input wire logic trigger,
  output logic active,
  output logic start
);

  logic [31:0] remaining;

  assign active = remaining != 32'h0;
  assign start = trigger && !active;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      remaining <= 32'h0;
    end else if (ce) begin
      if (start) begin
        remaining <= 32'(length);
      end else if (active) begin
        remaining <= remaining - 32'h1;
      end
    end
  end

endmodule : pulse_stretch

// ---- rtl/bcd_chain.sv ----
`timescale 1ns/1ps
module bcd_chain
  import timebase_pkg::*;
#(
  parameter int decades = b_decades
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Counting
  input wire logic clear,
  input wire logic advance,
  output logic [4*decades-1:0] digits,
  output logic carry_out
);

  logic [decades:0] carry;

  assign carry[0] = advance;
  assign carry_out = carry[decades];

  // Each decade rolls into the next on wrap
  for (genvar i = 0; i < decades; i++) begin : g_decade
    assign carry[i+1] = carry[i] && digits[4*i +: 4] == decade_last;
    always_ff @(posedge core_clk) begin
      if (!rstn) begin
        digits[4*i +: 4] <= 4'h0;
      end else if (ce) begin
        if (clear) begin
          digits[4*i +: 4] <= 4'h0;
        end else if (carry[i]) begin
          digits[4*i +: 4] <= carry[i+1] ? 4'h0 : digits[4*i +: 4] + 4'h1;
        end
      end
    end
  end

endmodule : bcd_chain

// ---- rtl/timebase_counter_b.sv ----
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module timebase_counter_b
  import timebase_pkg::*;
#(
  parameter int holdoff = holdoff_cycles,
  parameter int shaper = shaper_cycles,
  parameter int decades = b_decades
) (
  // Clock, enable and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Register bus
  input wire wb_req_type wb_req,
  output wb_rsp_type wb_rsp,
  // References and pulses
  input wire logic mains_ref,
  input wire logic crystal_tick,
  input wire logic external_pulse_source,
  input wire logic external_gate_b,
  // Resets
  input wire logic general_reset,
  input wire logic any_reset,
  // Outputs
  output logic inhibit,
  output logic count_state,
  output logic self_check_a,
  output logic gate_b_open,
  output logic [4*decades-1:0] count_b,
  output logic overflow_b
);

  logic [31:0] control;
  logic mains_prev;
  logic mains_active;
  logic mains_start;
  logic shaper_active;
  logic shaper_start;
  logic shaper_prev;
  logic [9:0] xtal_count;
  logic xtal_half;
  logic [3:0] first_div;
  logic [3:0] tenth_div;
  logic [3:0] minute_div;
  logic bus_hit;
  logic ack;
  logic [31:0] rd_data;
  logic carry_out;
  logic [31:0] dat_q;

  wire source_type source = source_type'(control[ctl_source_lsb +: 2]);
  wire mains50 = control[ctl_mains50];
  wire crystal = control[ctl_crystal];
  wire selfcheck = control[ctl_selfcheck];
  wire system_gate = control[ctl_system_gate];
  wire preset_idle = control[ctl_preset_idle];

  // Mains conditioner: one trigger per cycle
  wire mains_rise = mains_ref && !mains_prev;
  pulse_stretch #(.length(holdoff)) u_holdoff (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .trigger(mains_rise),
    .active(mains_active),
    .start(mains_start)
  );

  // Crystal countdown to 50 Hz
  wire xtal_wrap = crystal_tick && xtal_count == 10'(crystal_div - 1);
  wire xtal_50hz = xtal_wrap && xtal_half;
  wire ref_event = crystal ? xtal_50hz : mains_start;

  // Fundamental shaper, about 1 us
  pulse_stretch #(.length(shaper)) u_shaper (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .trigger(ref_event),
    .active(shaper_active),
    .start(shaper_start)
  );
  wire shaper_edge = shaper_active && !shaper_prev;

  // Start/stop bistable toggled by shaper unless resetting
  assign inhibit = any_reset;
  wire toggle = shaper_edge && !inhibit;

  // Divider chain
  wire fund_gated = shaper_edge && count_state;
  wire [3:0] detect = (mains50 || crystal) ? detect_50hz : detect_60hz;
  wire tick_10hz = fund_gated && (first_div + 4'h1) == detect;
  wire tenth_wrap = tick_10hz && tenth_div == decade_last;
  wire tick_min = tenth_wrap && minute_div == minute_last;

  // Channel B source select and gating
  wire b_input = source == source_external ? external_pulse_source :
                 source == source_tenth_second ? tick_10hz :
                 source == source_tenth_minute ? tick_min : 1'b0;
  assign gate_b_open = count_state && !inhibit && external_gate_b && system_gate && preset_idle;
  wire b_advance = b_input && gate_b_open;

  // Self-check pulses for channel A
  assign self_check_a = selfcheck && (crystal ? crystal_tick : shaper_edge);

  bcd_chain #(.decades(decades)) u_chain (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .clear(general_reset),
    .advance(b_advance),
    .digits(count_b),
    .carry_out(carry_out)
  );

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mains_prev <= 1'b0;
      shaper_prev <= 1'b0;
      count_state <= 1'b0;
      overflow_b <= 1'b0;
    end else if (ce) begin
      mains_prev <= mains_ref;
      shaper_prev <= shaper_active;
      if (general_reset) begin
        count_state <= 1'b0;
        overflow_b <= 1'b0;
      end else begin
        if (toggle) begin
          count_state <= !count_state;
        end
        if (carry_out) begin
          overflow_b <= 1'b1;
        end
      end
    end
  end

  // Dividers cleared by general reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      xtal_count <= 10'h0;
      xtal_half <= 1'b0;
      first_div <= 4'h0;
      tenth_div <= 4'h0;
      minute_div <= 4'h0;
    end else if (ce) begin
      if (general_reset) begin
        xtal_count <= 10'h0;
        xtal_half <= 1'b0;
        first_div <= 4'h0;
        tenth_div <= 4'h0;
        minute_div <= 4'h0;
      end else begin
        if (crystal_tick) begin
          xtal_count <= xtal_wrap ? 10'h0 : xtal_count + 10'h1;
        end
        if (xtal_wrap) begin
          xtal_half <= !xtal_half;
        end
        if (fund_gated) begin
          first_div <= tick_10hz ? 4'h0 : first_div + 4'h1;
        end
        if (tick_10hz) begin
          tenth_div <= tenth_wrap ? 4'h0 : tenth_div + 4'h1;
        end
        if (tenth_wrap) begin
          minute_div <= tick_min ? 4'h0 : minute_div + 4'h1;
        end
      end
    end
  end

  // Wishbone slave, one registered ack per request, a cycle after the strobe
  assign bus_hit = wb_req.cyc && wb_req.stb && !ack;
  wire sel_control = wb_req.adr == reg_control;
  wire sel_status = wb_req.adr == reg_status;
  wire sel_count = wb_req.adr == reg_count_b;
  wire [31:0] status_word = {26'h0, inhibit, overflow_b, gate_b_open, count_state, crystal, mains_active};
  assign rd_data = sel_control ? control :
                   sel_status ? status_word :
                   sel_count ? 32'(count_b) : 32'h0;
  // Writes land on the edge at which the master sees ack
  wire write_hit = ack && wb_req.cyc && wb_req.stb && wb_req.we && sel_control && wb_req.sel[0];
  assign wb_rsp.ack = ack;
  assign wb_rsp.dat = dat_q;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ack <= 1'b0;
      control <= ctl_reset_value;
      dat_q <= 32'h0;
    end else if (ce) begin
      ack <= bus_hit;
      if (bus_hit) begin
        dat_q <= rd_data;
      end
      if (write_hit) begin
        control[7:0] <= wb_req.dat[7:0];
      end
    end
  end

endmodule : timebase_counter_b

// ---- verification/timebase_counter_b_assertions.sv ----
`timescale 1ns/1ps
module timebase_counter_b_checker
  import timebase_pkg::*;
#(
  parameter int decades = b_decades
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Bus
  input wire wb_req_type wb_req,
  input wire wb_rsp_type wb_rsp,
  // Controls
  input wire logic external_gate_b,
  input wire logic general_reset,
  input wire logic any_reset,
  // Results
  input wire logic inhibit,
  input wire logic count_state,
  input wire logic gate_b_open,
  input wire logic [4*decades-1:0] count_b,
  input wire logic overflow_b
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_inhibit_tracks_reset: assert property (inhibit == any_reset) else $error("inhibit wrong");
  a_gate_needs_enables: assert property (gate_b_open |-> count_state && !inhibit && external_gate_b)
    else $error("gate open without enables");
  a_count_needs_gate: assert property ($past(rstn) && $changed(count_b) && !$past(general_reset)
    |-> $past(gate_b_open)) else $error("count moved with gate shut");
  a_digit_steps_bcd: assert property ($past(rstn) && $changed(count_b[3:0]) && !$past(general_reset)
    |-> count_b[3:0] == (($past(count_b[3:0]) == decade_last) ? 4'h0 : $past(count_b[3:0]) + 4'h1))
    else $error("digit step wrong");
  a_general_clears_all: assert property (general_reset && ce |=> count_b == '0 && !overflow_b && !count_state)
    else $error("general reset did not clear");
  a_reset_holds_state: assert property (any_reset && !general_reset && ce |=> $stable(count_state))
    else $error("bistable toggled in reset");
  a_overflow_sticks: assert property (overflow_b && !general_reset |=> overflow_b) else $error("overflow lost");
  a_ack_single_cycle: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack too long");
  a_ack_answers_req: assert property (ce && wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("ack missing");
  cover property (wb_rsp.ack);
  cover property (gate_b_open);
  cover property ($rose(count_state));
endmodule : timebase_counter_b_checker

bind timebase_counter_b timebase_counter_b_checker #(.decades(decades)) checker_i (.core_clk, .rstn, .ce, .wb_req,
  .wb_rsp, .external_gate_b, .general_reset, .any_reset, .inhibit, .count_state, .gate_b_open, .count_b, .overflow_b);

// ---- verification/ref_source.sv ----
`timescale 1ns/1ps
module ref_source (
  // Clock
  input wire logic core_clk,
  // Reference and pulse lines
  output logic mains_ref,
  output logic crystal_tick,
  output logic external_pulse_source
);
  initial begin
    mains_ref = 1'b0;
    crystal_tick = 1'b0;
    external_pulse_source = 1'b0;
  end
  // Oscillator ticking on every clock for n cycles
  task automatic ticks(input int n);
    crystal_tick <= 1'b1;
    repeat (n) @(posedge core_clk);
    crystal_tick <= 1'b0;
  endtask : ticks
  // One mains cycle whose high half carries a dip, as a noisy line would
  task automatic mains_cycle(input int half);
    mains_ref <= 1'b1;
    repeat (half) @(posedge core_clk);
    mains_ref <= 1'b0;
    repeat (2) @(posedge core_clk);
    mains_ref <= 1'b1;
    repeat (half) @(posedge core_clk);
    mains_ref <= 1'b0;
    repeat (4 * half) @(posedge core_clk);
  endtask : mains_cycle
  task automatic pulses(input int n);
    repeat (n) begin
      external_pulse_source <= 1'b1;
      @(posedge core_clk);
      external_pulse_source <= 1'b0;
      @(posedge core_clk);
    end
  endtask : pulses
endmodule : ref_source

// ---- verification/timebase_counter_b_tb.sv ----
`timescale 1ns/1ps
module timebase_counter_b_tb;
  import timebase_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic external_gate_b = 1'b1;
  logic general_reset = 1'b0;
  logic any_reset = 1'b0;
  logic ce = 1'b1;
  logic [3:0] wsel = 4'hf;
  wb_req_type req = '0;
  wb_rsp_type rsp;
  logic mains_ref, crystal_tick, ext_pulse, inhibit, count_state, gate_b_open, overflow_b, self_check_a;
  logic [23:0] count_b;
  logic [31:0] q;
  int err_total = 0;
  int cmp_count = 0;
  int sc_count = 0;
  int sc_base;
  always #4 core_clk = ~core_clk;
  ref_source src (.core_clk, .mains_ref, .crystal_tick, .external_pulse_source(ext_pulse));
  timebase_counter_b #(.holdoff(20), .shaper(3)) uut (.core_clk, .rstn, .ce, .wb_req(req), .wb_rsp(rsp),
    .mains_ref, .crystal_tick, .external_pulse_source(ext_pulse), .external_gate_b, .general_reset, .any_reset,
    .inhibit, .count_state, .self_check_a, .gate_b_open, .count_b, .overflow_b);
  // Self-check pulses handed to channel A
  always @(posedge core_clk) begin
    if (self_check_a === 1'b1) begin
      sc_count <= sc_count + 1;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    req <= '{adr: a, dat: d, sel: wsel, we: we, cyc: 1'b1, stb: 1'b1};
    do begin
      @(posedge core_clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    if (n == 50) err_total++;
    r = rsp.dat;
    req <= '0;
    @(posedge core_clk);
  endtask : wb
  // Load control, then one general reset cycle
  task automatic restart(input logic [31:0] ctl);
    logic [31:0] r;
    wb(1'b1, reg_control, ctl, r);
    general_reset <= 1'b1;
    any_reset <= 1'b1;
    @(posedge core_clk);
    general_reset <= 1'b0;
    any_reset <= 1'b0;
    @(posedge core_clk);
  endtask : restart
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #600000;
    err_total++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    wb(1'b0, reg_control, '0, q);
    chk("control", ctl_reset_value, q);
    wb(1'b0, 32'h0000_0040, '0, q);
    chk("unmapped", '0, q);
    src.mains_cycle(4);
    chk("count_state", 32'h1, {31'h0, count_state});
    src.pulses(25);
    chk("count_b", 32'h25, {8'h0, count_b});
    src.pulses(80);
    chk("count_b", 32'h105, {8'h0, count_b});
    external_gate_b <= 1'b0;
    src.pulses(5);
    chk("count_b", 32'h105, {8'h0, count_b});
    external_gate_b <= 1'b1;
    ce <= 1'b0;
    src.pulses(5);
    ce <= 1'b1;
    chk("count_b", 32'h105, {8'h0, count_b});
    wb(1'b1, reg_control, 32'h0000_0040, q);
    src.pulses(5);
    chk("count_b", 32'h105, {8'h0, count_b});
    wb(1'b1, reg_control, ctl_reset_value, q);
    wb(1'b0, reg_status, '0, q);
    chk("status", 32'h0c, q);
    wb(1'b0, reg_count_b, '0, q);
    chk("count_reg", 32'h105, q);
    wsel = 4'h0;
    wb(1'b1, reg_control, 32'h0000_0061, q);
    wsel = 4'hf;
    wb(1'b0, reg_control, '0, q);
    chk("control", ctl_reset_value, q);
    any_reset <= 1'b1;
    src.pulses(5);
    chk("inhibit", 32'h1, {31'h0, inhibit});
    src.mains_cycle(4);
    chk("count_state", 32'h1, {31'h0, count_state});
    chk("count_b", 32'h105, {8'h0, count_b});
    any_reset <= 1'b0;
    for (int s = 1; s < 3; s++) begin
      wb(1'b1, reg_control, ctl_reset_value | s, q);
      src.pulses(10);
      chk("count_b", 32'h105, {8'h0, count_b});
    end
    restart(ctl_reset_value);
    chk("count_b", 32'h0, {8'h0, count_b});
    chk("count_state", 32'h0, {31'h0, count_state});
    src.mains_cycle(4);
    src.mains_cycle(4);
    chk("count_state", 32'h0, {31'h0, count_state});
    src.pulses(3);
    chk("count_b", 32'h0, {8'h0, count_b});
    restart(ctl_reset_value | 32'h1);
    repeat (11) src.mains_cycle(4);
    chk("count_b", 32'h0, {8'h0, count_b});
    src.mains_cycle(4);
    chk("count_b", 32'h1, {8'h0, count_b});
    restart(ctl_reset_value | 32'h5);
    repeat (9) src.mains_cycle(4);
    chk("count_b", 32'h0, {8'h0, count_b});
    src.mains_cycle(4);
    chk("count_b", 32'h1, {8'h0, count_b});
    restart(ctl_reset_value | 32'h2);
    repeat (708) src.mains_cycle(4);
    chk("count_b", 32'h0, {8'h0, count_b});
    repeat (12) src.mains_cycle(4);
    chk("count_b", 32'h1, {8'h0, count_b});
    restart(ctl_reset_value | 32'h10);
    sc_base = sc_count;
    src.mains_cycle(4);
    chk("self_check_a", 32'h1, sc_count - sc_base);
    restart(ctl_reset_value | 32'h19);
    wb(1'b0, reg_status, '0, q);
    chk("status", 32'h02, q);
    sc_base = sc_count;
    src.ticks(19999);
    repeat (4) @(posedge core_clk);
    chk("count_b", 32'h0, {8'h0, count_b});
    src.ticks(1);
    repeat (4) @(posedge core_clk);
    chk("count_b", 32'h1, {8'h0, count_b});
    chk("self_check_a", 32'h4e20, sc_count - sc_base);
    complete_run();
  end
endmodule : timebase_counter_b_tb
